//--- verilog/pio_hold_pkg.sv
// shared constants, register map and carrier types of the input pin bank
package pio_hold_pkg;

    localparam int NUM_BANKS = 4;
    localparam int PINS_PER_BANK = 8;
    localparam int NUM_PINS = NUM_BANKS * PINS_PER_BANK;
    localparam int DIFF_BANK = 3;
    localparam int DIFF_BASE = DIFF_BANK * PINS_PER_BANK;
    localparam int NUM_DIFF_PAIRS = PINS_PER_BANK / 2;
    localparam int NUM_GLOBAL_BUFFER = 8;
    localparam int GLOBAL_BUFFER_PIN_STRIDE = 4;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_INREG_SEL = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_GATE_SEL = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_PULLUP_EN = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_DIFF_EN = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_GLOBAL_BUFFER_SRC = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_PIN_VALUE = 8'h18;
    localparam logic [ADDR_W-1:0] ADDR_PIN_KNOWN = 8'h1C;
    localparam logic [ADDR_W-1:0] ADDR_GLOBAL_BUFFER_STATE = 8'h20;

    localparam logic [NUM_PINS-1:0] INREG_SEL_RST = 32'h0000_0000;
    localparam logic [NUM_PINS-1:0] GATE_SEL_RST = 32'h0000_0000;
    localparam logic [NUM_PINS-1:0] PULLUP_EN_RST = 32'h00FF_FFFF;
    localparam logic [NUM_PINS-1:0] PULLUP_MASK = 32'h00FF_FFFF;
    localparam logic [NUM_PINS-1:0] ALL_PINS = 32'hFFFF_FFFF;
    localparam logic [NUM_DIFF_PAIRS-1:0] DIFF_EN_RST = 4'h0;
    localparam logic [NUM_GLOBAL_BUFFER-1:0] GLOBAL_BUFFER_SRC_RST = 8'h00;

    localparam int STAT_CFG_BUSY_BIT = 0;
    localparam int STAT_HOLD_LSB = 4;

    // value and knowledge of each pin travel together
    typedef struct packed {
        logic [NUM_PINS-1:0] level;
        logic [NUM_PINS-1:0] known;
    } pin_bus_t;

    function automatic int bank_of(input int pin);
        return pin / PINS_PER_BANK;
    endfunction

    function automatic int global_buffer_pin(input int buf_idx);
        return buf_idx * GLOBAL_BUFFER_PIN_STRIDE;
    endfunction

endpackage

//--- verilog/pad_sync.sv
// three-stage pad synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pad_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= d_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // s1 is only read by s2; a bit moves once s2 and s3 agree
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            q_o <= '0;
        end else begin
            q_o <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & q_o);
        end
    end
endmodule // pad_sync
`default_nettype wire

//--- verilog/hold_latch.sv
// per-bank freeze latch for non-registered inputs
`timescale 1ns/1ps
`default_nettype none
module hold_latch
    import pio_hold_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic hold_i,
    input wire logic [PINS_PER_BANK-1:0] gate_i,
    input wire logic [PINS_PER_BANK-1:0] d_level_i,
    input wire logic [PINS_PER_BANK-1:0] d_known_i,
    output logic [PINS_PER_BANK-1:0] q_level_o,
    output logic [PINS_PER_BANK-1:0] q_known_o
);
    logic [PINS_PER_BANK-1:0] cap_level_q;
    logic [PINS_PER_BANK-1:0] cap_known_q;
    logic [PINS_PER_BANK-1:0] frozen;

    // clocked capture instead of a real latch keeps the held value clean
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            cap_level_q <= '0;
            cap_known_q <= '0;
        end else if (!hold_i) begin
            cap_level_q <= d_level_i; // R16
            cap_known_q <= d_known_i;
        end
    end

    assign frozen = gate_i & {PINS_PER_BANK{hold_i}}; // R2
    assign q_level_o = (frozen & cap_level_q) | (~frozen & d_level_i); // R3
    assign q_known_o = (frozen & cap_known_q) | (~frozen & d_known_i);
endmodule // hold_latch
`default_nettype wire

//--- verilog/pio_input_bank.sv
// input side of a four-bank programmable pin array with freeze latches
// Operation
// R1 - each pin reaches fabric directly or through an input register
// R2 - freeze high: gated non-registered inputs hold their last value
// R3 - freeze low: input follows pad; floating reads 1 only with pull-up
// R4 - pins bypassing the freeze latch always pass the live pad value
// R5 - freeze-latch selection is fixed by configuration, not at run time
// R6 - registered inputs ignore freeze; held only by their clock enable
// R7 - four freeze controls, one per bank, each acting on its own bank
// R8 - each freeze control is driven from the fabric
// R9 - global clock pins feed global buffers directly, never frozen
// R10 - a global buffer fed from an ordinary pin follows its freeze latch
// R11 - during configuration pull-ups of banks 0, 1, 2 are forced on
// R12 - after configuration each pull-up follows its own enable bit
// R13 - differential bank pins have no pull-up; floating reads undefined
// R14 - differential pair resolves to the true pin value
// R15 - unused test clock, data and mode inputs must be tied low outside
// R16 - freeze latch transparent while low, holds glitch-free while high
//
// Chosen here: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
module pio_input_bank
    import pio_hold_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [DATA_W-1:0] pwdata_i,
    output logic [DATA_W-1:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic cfg_busy_i,
    input wire logic [NUM_BANKS-1:0] hold_ctrl_i,
    input wire logic [NUM_BANKS-1:0] in_clk_en_i,
    input wire logic [NUM_PINS-1:0] pad_level_i,
    input wire logic [NUM_PINS-1:0] pad_driven_i,
    input wire logic [NUM_GLOBAL_BUFFER-1:0] global_clock_pin_i,
    output pin_bus_t fabric_o,
    output logic [NUM_GLOBAL_BUFFER-1:0] global_buffer_o,
    output logic [NUM_PINS-1:0] pullup_on_o
);
    ////////////////////////////////////////////////////////////////////////
    logic [NUM_PINS-1:0] inreg_sel_q;
    logic [NUM_PINS-1:0] gate_sel_q;
    logic [NUM_PINS-1:0] pullup_en_q;
    logic [NUM_DIFF_PAIRS-1:0] diff_en_q;
    logic [NUM_GLOBAL_BUFFER-1:0] global_buffer_src_q;
    logic [DATA_W-1:0] prdata_q;
    logic [NUM_PINS-1:0] lvl_s;
    logic [NUM_PINS-1:0] drv_s;
    logic [NUM_GLOBAL_BUFFER-1:0] gclk_s;
    logic [NUM_PINS-1:0] pullup_on;
    logic [NUM_PINS-1:0] ce_vec;
    pin_bus_t raw;
    pin_bus_t live;
    pin_bus_t gated;
    pin_bus_t inreg_q;
    pin_bus_t fabric_q;
    logic [NUM_GLOBAL_BUFFER-1:0] global_buffer_q;
    logic setup_ph;
    logic access_ph;
    logic addr_ok;
    logic ro_addr;
    logic gate_locked;
    logic wr_err;
    logic wr_fire;
    logic [DATA_W-1:0] rd_mux;

    ////////////////////////////////////////////////////////////////////////
    // pad and global clock pins come from outside the clock domain
    pad_sync #(
        .WIDTH(2 * NUM_PINS)
    ) u_pad_sync (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .d_i({pad_driven_i, pad_level_i}),
        .q_o({drv_s, lvl_s})
    );

    pad_sync #(
        .WIDTH(NUM_GLOBAL_BUFFER)
    ) u_gclk_sync (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .d_i(global_clock_pin_i),
        .q_o(gclk_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // bank 3 is left out of the mask: it has no pull-up at all
    assign pullup_on = (cfg_busy_i ? ALL_PINS : pullup_en_q)
                       & PULLUP_MASK; // R11 R12 R13
    assign pullup_on_o = pullup_on;

    // undriven pad: 1 under pull-up, otherwise unknown (reported as 0)
    assign raw.level = (drv_s & lvl_s) | (~drv_s & pullup_on); // R3
    assign raw.known = drv_s | pullup_on;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
            localparam int B = bank_of(gi);
            assign ce_vec[gi] = in_clk_en_i[B];
            if (B == DIFF_BANK) begin : g_diff
                localparam int TRUE_IDX = gi | 1;
                localparam int PAIR = (gi - DIFF_BASE) / 2;
                // R14
                assign live.level[gi] = diff_en_q[PAIR] ?
                                        raw.level[TRUE_IDX] : raw.level[gi];
                assign live.known[gi] = diff_en_q[PAIR] ?
                                        raw.known[TRUE_IDX] : raw.known[gi];
            end else begin : g_single
                assign live.level[gi] = raw.level[gi];
                assign live.known[gi] = raw.known[gi];
            end
        end
        for (gi = 0; gi < NUM_BANKS; gi++) begin : g_bank
            localparam int LO = gi * PINS_PER_BANK;
            // each bank sees only its own fabric-driven control
            hold_latch u_hold (
                .clk_sys_i(clk_sys_i),
                .sys_rst_i(sys_rst_i),
                .hold_i(hold_ctrl_i[gi]), // R7 R8
                .gate_i(gate_sel_q[LO +: PINS_PER_BANK]), // R4
                .d_level_i(live.level[LO +: PINS_PER_BANK]),
                .d_known_i(live.known[LO +: PINS_PER_BANK]),
                .q_level_o(gated.level[LO +: PINS_PER_BANK]),
                .q_known_o(gated.known[LO +: PINS_PER_BANK])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // registered inputs bypass the freeze latch entirely
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            inreg_q <= '0;
        end else begin
            inreg_q.level <= (ce_vec & live.level)
                             | (~ce_vec & inreg_q.level); // R6
            inreg_q.known <= (ce_vec & live.known)
                             | (~ce_vec & inreg_q.known);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            fabric_q <= '0;
        end else begin
            fabric_q.level <= (inreg_sel_q & inreg_q.level)
                              | (~inreg_sel_q & gated.level); // R1
            fabric_q.known <= (inreg_sel_q & inreg_q.known)
                              | (~inreg_sel_q & gated.known);
        end
    end
    assign fabric_o = fabric_q;

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            global_buffer_q <= '0;
        end else begin
            for (int n = 0; n < NUM_GLOBAL_BUFFER; n++) begin
                global_buffer_q[n] <= global_buffer_src_q[n] ? gated.level[global_buffer_pin(n)]
                                           : gclk_s[n]; // R9 R10
            end
        end
    end
    assign global_buffer_o = global_buffer_q;

    ////////////////////////////////////////////////////////////////////////
    // APB slave, zero wait states
    assign setup_ph = psel_i & ~penable_i;
    assign access_ph = psel_i & penable_i;
    assign pready_o = 1'b1;
    assign addr_ok = (paddr_i == ADDR_STATUS) || (paddr_i == ADDR_INREG_SEL)
                     || (paddr_i == ADDR_GATE_SEL)
                     || (paddr_i == ADDR_PULLUP_EN)
                     || (paddr_i == ADDR_DIFF_EN)
                     || (paddr_i == ADDR_GLOBAL_BUFFER_SRC)
                     || (paddr_i == ADDR_PIN_VALUE)
                     || (paddr_i == ADDR_PIN_KNOWN)
                     || (paddr_i == ADDR_GLOBAL_BUFFER_STATE);
    assign ro_addr = (paddr_i == ADDR_STATUS) || (paddr_i == ADDR_PIN_VALUE)
                     || (paddr_i == ADDR_PIN_KNOWN)
                     || (paddr_i == ADDR_GLOBAL_BUFFER_STATE);
    // selection of frozen pins belongs to the image; later writes bounce
    assign gate_locked = (paddr_i == ADDR_GATE_SEL) && !cfg_busy_i; // R5
    assign wr_err = pwrite_i && (ro_addr || gate_locked);
    assign pslverr_o = access_ph && (!addr_ok || wr_err);
    assign wr_fire = access_ph && pwrite_i && addr_ok && !wr_err;

    always_comb begin
        rd_mux = '0;
        case (paddr_i)
            ADDR_STATUS: begin
                rd_mux[STAT_CFG_BUSY_BIT] = cfg_busy_i;
                rd_mux[STAT_HOLD_LSB +: NUM_BANKS] = hold_ctrl_i;
            end
            ADDR_INREG_SEL: rd_mux = inreg_sel_q;
            ADDR_GATE_SEL: rd_mux = gate_sel_q;
            ADDR_PULLUP_EN: rd_mux = pullup_en_q;
            ADDR_DIFF_EN: rd_mux[NUM_DIFF_PAIRS-1:0] = diff_en_q;
            ADDR_GLOBAL_BUFFER_SRC: rd_mux[NUM_GLOBAL_BUFFER-1:0] = global_buffer_src_q;
            ADDR_PIN_VALUE: rd_mux = fabric_q.level;
            ADDR_PIN_KNOWN: rd_mux = fabric_q.known;
            ADDR_GLOBAL_BUFFER_STATE: rd_mux[NUM_GLOBAL_BUFFER-1:0] = global_buffer_q;
            default: rd_mux = '0;
        endcase
    end

    // read data is caught in the setup cycle and stands through access
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            prdata_q <= '0;
        end else if (setup_ph) begin
            prdata_q <= rd_mux;
        end
    end
    assign prdata_o = prdata_q;

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            inreg_sel_q <= INREG_SEL_RST;
            gate_sel_q <= GATE_SEL_RST;
            pullup_en_q <= PULLUP_EN_RST;
            diff_en_q <= DIFF_EN_RST;
            global_buffer_src_q <= GLOBAL_BUFFER_SRC_RST;
        end else if (wr_fire) begin
            case (paddr_i)
                ADDR_INREG_SEL: inreg_sel_q <= pwdata_i;
                ADDR_GATE_SEL: gate_sel_q <= pwdata_i; // R5
                ADDR_PULLUP_EN: pullup_en_q <= pwdata_i & PULLUP_MASK;
                ADDR_DIFF_EN: diff_en_q <= pwdata_i[NUM_DIFF_PAIRS-1:0];
                ADDR_GLOBAL_BUFFER_SRC: global_buffer_src_q <= pwdata_i[NUM_GLOBAL_BUFFER-1:0];
                default: global_buffer_src_q <= global_buffer_src_q;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    property p_pullup_forced;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        cfg_busy_i |-> (pullup_on_o == PULLUP_MASK);
    endproperty
    a_pullup_forced: assert property (p_pullup_forced) // R11
        else $error("pull-ups not forced during configuration");

    property p_pullup_cfg;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        !cfg_busy_i |-> (pullup_on_o == (pullup_en_q & PULLUP_MASK));
    endproperty
    a_pullup_cfg: assert property (p_pullup_cfg) // R12
        else $error("pull-up does not follow its enable bit");

    property p_no_diff_pullup;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        pullup_on_o[NUM_PINS-1:DIFF_BASE] == '0;
    endproperty
    a_no_diff_pullup: assert property (p_no_diff_pullup) // R13
        else $error("pull-up active in differential bank");

    property p_gate_fixed;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        !cfg_busy_i && $past(!cfg_busy_i) |-> $stable(gate_sel_q);
    endproperty
    a_gate_fixed: assert property (p_gate_fixed) // R5
        else $error("freeze selection changed after configuration");

    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_chk
            localparam int B = bank_of(gi);
            property p_freeze_hold;
                @(posedge clk_sys_i) disable iff (sys_rst_i)
                (hold_ctrl_i[B] && gate_sel_q[gi] && !inreg_sel_q[gi])[*2]
                |=> $stable(fabric_q.level[gi]);
            endproperty
            a_freeze_hold: assert property (p_freeze_hold) // R2
                else $error("frozen input moved");

            // sampled reset keeps the release edge out of the antecedent
            property p_bypass_live;
                @(posedge clk_sys_i) disable iff (sys_rst_i)
                !sys_rst_i && !gate_sel_q[gi] && !inreg_sel_q[gi]
                |=> fabric_q.level[gi] == $past(live.level[gi]);
            endproperty
            a_bypass_live: assert property (p_bypass_live) // R4
                else $error("bypass pin does not follow pad");

            property p_reg_path;
                @(posedge clk_sys_i) disable iff (sys_rst_i)
                inreg_sel_q[gi] && ce_vec[gi] ##1 inreg_sel_q[gi]
                |=> fabric_q.level[gi] == $past(live.level[gi], 2);
            endproperty
            a_reg_path: assert property (p_reg_path) // R1
                else $error("registered input path wrong");

            property p_reg_stall;
                @(posedge clk_sys_i) disable iff (sys_rst_i)
                (inreg_sel_q[gi] && !ce_vec[gi])[*2]
                |=> $stable(fabric_q.level[gi]);
            endproperty
            a_reg_stall: assert property (p_reg_stall) // R6
                else $error("registered input moved without enable");

            property p_transparent;
                @(posedge clk_sys_i) disable iff (sys_rst_i)
                !hold_ctrl_i[B] |-> gated.level[gi] == live.level[gi];
            endproperty
            a_transparent: assert property (p_transparent) // R16
                else $error("freeze latch not transparent");

            if (B != DIFF_BANK) begin : g_float
                property p_float_pullup;
                    @(posedge clk_sys_i) disable iff (sys_rst_i)
                    !sys_rst_i && !inreg_sel_q[gi] && !drv_s[gi]
                    && pullup_on[gi] && !(hold_ctrl_i[B] && gate_sel_q[gi])
                    |=> fabric_q.level[gi] && fabric_q.known[gi];
                endproperty
                a_float_pullup: assert property (p_float_pullup) // R3
                    else $error("floating pin with pull-up not high");
            end else if (gi % 2 == 0) begin : g_pair
                property p_diff_true;
                    @(posedge clk_sys_i) disable iff (sys_rst_i)
                    diff_en_q[(gi - DIFF_BASE) / 2]
                    |-> live.level[gi] == raw.level[gi + 1];
                endproperty
                a_diff_true: assert property (p_diff_true) // R14
                    else $error("pair not resolved to true pin");
            end
        end
        for (gi = 0; gi < NUM_GLOBAL_BUFFER; gi++) begin : g_gchk
            property p_global_buffer_direct;
                @(posedge clk_sys_i) disable iff (sys_rst_i)
                !sys_rst_i && !global_buffer_src_q[gi]
                |=> global_buffer_o[gi] == $past(gclk_s[gi]);
            endproperty
            a_global_buffer_direct: assert property (p_global_buffer_direct) // R9
                else $error("global clock pin path blocked");

            property p_global_buffer_frozen;
                @(posedge clk_sys_i) disable iff (sys_rst_i)
                (global_buffer_src_q[gi] && gate_sel_q[global_buffer_pin(gi)]
                 && hold_ctrl_i[bank_of(global_buffer_pin(gi))])[*2]
                |=> $stable(global_buffer_o[gi]);
            endproperty
            a_global_buffer_frozen: assert property (p_global_buffer_frozen) // R10
                else $error("pin-fed global buffer not frozen");
        end
    endgenerate
endmodule // pio_input_bank
`default_nettype wire

//--- testbench/pad_board_model.sv
// board-side model of the signals driven onto the device pads
`timescale 1ns/1ps
`default_nettype none
module pad_board_model (
    input wire logic clk_sys_i,
    input wire logic [31:0] want_level_i,
    input wire logic [31:0] want_drive_i,
    input wire logic [7:0] want_gclk_i,
    output logic [31:0] pad_level_o,
    output logic [31:0] pad_driven_o,
    output logic [7:0] gclk_o
);
    logic flip = 1'b0;

    // a released pad toggles every cycle so a float never looks stable
    always @(posedge clk_sys_i) begin
        flip <= ~flip;
        pad_level_o <= (want_level_i & want_drive_i)
            | (~want_drive_i & {32{flip}});
        pad_driven_o <= want_drive_i;
        gclk_o <= want_gclk_i;
    end
    // test clock, data and mode pins are not modelled; held low off-chip
endmodule // pad_board_model
`default_nettype wire

//--- testbench/tb_pio_input_bank.sv
// self-checking bench for the input pin bank
`timescale 1ns/1ps
`default_nettype none
module tb_pio_input_bank
    import pio_hold_pkg::*;
();
    logic clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr;
    logic cfg_busy, errv;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rdv;
    logic [NUM_PINS-1:0] want_level, want_drive, pad_level, pad_driven;
    logic [NUM_PINS-1:0] pullup_on;
    logic [NUM_BANKS-1:0] hold_ctrl, in_clk_en;
    logic [NUM_GLOBAL_BUFFER-1:0] want_gclk, gclk, global_buffer;
    pin_bus_t fabric;
    int errors, tests_run;
    localparam logic [31:0] PAT_A = 32'h5A5A_3C3C;
    localparam logic [31:0] PAT_B = 32'hA5A5_C3C3;

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    pio_input_bank pio_input_bank_inst (.clk_sys_i(clk_sys),
        .sys_rst_i(sys_rst), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .cfg_busy_i(cfg_busy), .hold_ctrl_i(hold_ctrl),
        .in_clk_en_i(in_clk_en), .pad_level_i(pad_level),
        .pad_driven_i(pad_driven), .global_clock_pin_i(gclk),
        .fabric_o(fabric), .global_buffer_o(global_buffer), .pullup_on_o(pullup_on));
    pad_board_model pad_board_model_inst (.clk_sys_i(clk_sys),
        .want_level_i(want_level), .want_drive_i(want_drive),
        .want_gclk_i(want_gclk), .pad_level_o(pad_level),
        .pad_driven_o(pad_driven), .gclk_o(gclk));

    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] mix(input logic [31:0] a, b, m);
        return (a & ~m) | (b & m);
    endfunction

    // pad changes need the sync chain plus one output stage
    task automatic settle();
        repeat (8) @(posedge clk_sys);
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            errors++;
            finish_test();
        end
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic ee);
        apb(1'b1, a, d);
        check({31'h0, errv}, {31'h0, ee});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ex,
                      input logic ee);
        apb(1'b0, a, '0);
        check(rdv, ex);
        check({31'h0, errv}, {31'h0, ee});
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rd(ADDR_INREG_SEL, INREG_SEL_RST, 1'b0);
        rd(ADDR_GATE_SEL, GATE_SEL_RST, 1'b0);
        rd(ADDR_PULLUP_EN, PULLUP_EN_RST, 1'b0);
        rd(ADDR_DIFF_EN, {28'h0, DIFF_EN_RST}, 1'b0);
        rd(ADDR_GLOBAL_BUFFER_SRC, {24'h0, GLOBAL_BUFFER_SRC_RST}, 1'b0);
        rd(8'h24, '0, 1'b1);
        wr(ADDR_STATUS, 32'h0000_00F0, 1'b1);
        hold_ctrl <= 4'hA;
        rd(ADDR_STATUS, 32'h0000_00A1, 1'b0);
        hold_ctrl <= 4'h0;
        wr(ADDR_GATE_SEL, 32'h0000_0F1F, 1'b0);
        cfg_busy <= 1'b0;
        wr(ADDR_GATE_SEL, '0, 1'b1);
        rd(ADDR_GATE_SEL, 32'h0000_0F1F, 1'b0);
        cfg_busy <= 1'b1;
        $display("test registers done");
    endtask

    task automatic t_pull();
        wr(ADDR_PULLUP_EN, '0, 1'b0);
        settle();
        check(pullup_on, PULLUP_MASK);
        check(fabric.known, PULLUP_MASK);
        check(fabric.level, PULLUP_MASK);
        cfg_busy <= 1'b0;
        settle();
        check(pullup_on, '0);
        check(fabric.known, '0);
        rd(ADDR_PIN_KNOWN, '0, 1'b0);
        wr(ADDR_PULLUP_EN, ALL_PINS, 1'b0);
        rd(ADDR_PULLUP_EN, PULLUP_MASK, 1'b0);
        check(pullup_on, PULLUP_MASK);
        $display("test pull-ups done");
    endtask

    task automatic t_freeze();
        want_drive <= ALL_PINS;
        want_level <= PAT_A;
        settle();
        check(fabric.level, PAT_A);
        check(fabric.known, ALL_PINS);
        rd(ADDR_PIN_VALUE, PAT_A, 1'b0);
        hold_ctrl <= 4'h1;
        settle();
        want_level <= PAT_B;
        settle();
        check(fabric.level, mix(PAT_B, PAT_A, 32'h0000_001F));
        hold_ctrl <= 4'h0;
        settle();
        check(fabric.level, PAT_B);
        $display("test freeze done");
    endtask

    task automatic t_inreg();
        wr(ADDR_INREG_SEL, 32'h0000_0003, 1'b0);
        settle();
        in_clk_en <= 4'h0;
        hold_ctrl <= 4'h1;
        want_level <= PAT_A;
        settle();
        check(fabric.level, mix(PAT_A, PAT_B, 32'h0000_001F));
        in_clk_en <= 4'hF;
        settle();
        check(fabric.level, mix(PAT_A, PAT_B, 32'h0000_001C));
        hold_ctrl <= 4'h0;
        wr(ADDR_INREG_SEL, '0, 1'b0);
        $display("test input register done");
    endtask

    task automatic t_diff();
        wr(ADDR_DIFF_EN, 32'h0000_0001, 1'b0);
        want_level <= 32'h0200_0000;
        settle();
        check({30'h0, fabric.level[25:24]}, 32'h0000_0003);
        want_level <= 32'h0100_0000;
        settle();
        check({30'h0, fabric.level[25:24]}, '0);
        check({30'h0, fabric.known[25:24]}, 32'h0000_0003);
        wr(ADDR_DIFF_EN, '0, 1'b0);
        $display("test differential done");
    endtask

    task automatic t_global_buffer();
        want_level <= 32'h0000_0010;
        want_gclk <= 8'h0D;
        wr(ADDR_GLOBAL_BUFFER_SRC, 32'h0000_0002, 1'b0);
        settle();
        check({24'h0, global_buffer}, 32'h0000_000F);
        hold_ctrl <= 4'hF;
        settle();
        want_level <= '0;
        want_gclk <= 8'hF0;
        settle();
        check({24'h0, global_buffer}, 32'h0000_00F2);
        hold_ctrl <= 4'h0;
        settle();
        check({24'h0, global_buffer}, 32'h0000_00F0);
        rd(ADDR_GLOBAL_BUFFER_STATE, 32'h0000_00F0, 1'b0);
        $display("test global buffers done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        errors = 0;
        tests_run = 0;
        sys_rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        cfg_busy = 1'b1;
        hold_ctrl = '0;
        in_clk_en = 4'hF;
        want_level = '0;
        want_drive = '0;
        want_gclk = '0;
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_regs();
        t_pull();
        t_freeze();
        t_inreg();
        t_diff();
        t_global_buffer();
        finish_test();
    end

    // a hang counts as a mismatch and still reaches the verdict
    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        finish_test();
    end
endmodule // tb_pio_input_bank
`default_nettype wire
